/* File: logic/core_sfr_regs.vh */
// Offsets, reset values and codes of the core special-register bank
`ifndef CORE_SFR_REGS_VH
`define CORE_SFR_REGS_VH

// ==========================================================
// Offsets
`define OFS_IO_LATCH_A 8'h80
`define OFS_STACK_TOP 8'h81
`define OFS_DP_LOW 8'h82
`define OFS_DP_HIGH 8'h83
`define OFS_IO_LATCH_B 8'h90
`define OFS_IO_SEL_B 8'h91
`define OFS_ERASE_TRIGGER 8'h94
`define OFS_SERIAL_ROM_BYTE 8'h9e
`define OFS_SERIAL_ROM_CMD 8'h9f
`define OFS_IO_LATCH_C 8'ha0
`define OFS_IO_SEL_C 8'ha1
`define OFS_IO_SEL_A 8'ha2
`define OFS_FLASH_CTRL 8'hb2
`define OFS_ERASE_PAGE 8'hb7
`define OFS_FLAGS_WORD 8'hd0
`define OFS_ACCUMULATOR 8'he0

// ==========================================================
// Fields
`define FLAGS_PARITY_BIT 0
`define FLAGS_USER1_BIT 1
`define FLAGS_WRAP_BIT 2
`define FLAGS_BANK_LO 3
`define FLAGS_BANK_HI 4
`define FLAGS_USER0_BIT 5
`define FLAGS_HALF_BIT 6
`define FLAGS_CARRY_BIT 7
`define FLASH_CTRL_ALLOW_BIT 1
`define PAGE_INDEX_MAX 8'h7f

// ==========================================================
// Reset values and codes
`define RST_IO_LATCH_A 8'hff
`define RST_IO_LATCH_B 8'hff
`define RST_IO_LATCH_C 8'h00
`define RST_IO_SEL 8'h00
`define RST_STACK_TOP 8'h07
`define RST_FLAGS_WORD 8'h00
`define RST_DP 8'h00
`define RST_FETCH 16'h0000
`define RST_ERASE_TRIGGER 8'h00
`define RST_ERASE_PAGE 8'h00
`define RST_SERIAL_ROM 8'h00
`define CODE_PAGE_ERASE 8'h55
`define CODE_BULK_ERASE 8'haa
`define READ_UNMAPPED 8'h00

`endif

/* File: logic/mpu_core_special_registers.v */
// Special-function register bank of the 8-bit processor core
`timescale 1ns/1ps
`include "core_sfr_regs.vh"

module mpu_core_special_registers (
	input wire clk_sys,
	input wire rst,
	// Special-register access from the core
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	output reg [7:0] sfr_rdata,
	// Datapath events
	input wire [7:0] accumulator_reg,
	input wire alu_flags_we,
	input wire carry_flag_in,
	input wire half_carry_flag_in,
	input wire signed_wrap_flag_in,
	input wire stack_push,
	input wire stack_pop,
	input wire fetch_advance,
	input wire fetch_load,
	input wire [15:0] fetch_load_value,
	input wire data_pointer_load,
	input wire [15:0] data_pointer_load_value,
	input wire data_pointer_inc,
	output reg [7:0] processor_flags_word,
	output reg [7:0] register_bank_base,
	output reg [7:0] stack_top,
	output reg [15:0] data_pointer_full,
	output reg [15:0] fetch_counter,
	// Digital I/O pins
	input wire [7:0] io_pin_a_in,
	output reg [7:0] io_pin_a_out,
	output reg [7:0] io_pin_a_oe,
	input wire [7:0] io_pin_b_in,
	output reg [7:0] io_pin_b_out,
	output reg [7:0] io_pin_b_oe,
	input wire [7:0] io_pin_c_in,
	output reg [7:0] io_pin_c_out,
	output reg [7:0] io_pin_c_oe,
	// Flash controller
	input wire debug_port_enabled,
	output reg page_erase_start,
	output reg bulk_erase_start,
	output reg [6:0] erase_page_out,
	// Serial ROM engine
	output reg [7:0] serial_rom_byte,
	output reg [7:0] serial_rom_command,
	output reg serial_rom_start
);

// ==========================================================
// Pin synchronisers
reg [7:0] pin_a_meta_r;
reg [7:0] pin_b_meta_r;
reg [7:0] pin_c_meta_r;
reg [7:0] pin_a_r;
reg [7:0] pin_b_r;
reg [7:0] pin_c_r;

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		pin_a_meta_r <= 8'h00;
		pin_b_meta_r <= 8'h00;
		pin_c_meta_r <= 8'h00;
		pin_a_r <= 8'h00;
		pin_b_r <= 8'h00;
		pin_c_r <= 8'h00;
	end else begin
		pin_a_meta_r <= io_pin_a_in;
		pin_b_meta_r <= io_pin_b_in;
		pin_c_meta_r <= io_pin_c_in;
		pin_a_r <= pin_a_meta_r;
		pin_b_r <= pin_b_meta_r;
		pin_c_r <= pin_c_meta_r;
	end
end

// ==========================================================
// Write decode
wire wr_flags = sfr_wr && (sfr_addr == `OFS_FLAGS_WORD);
wire wr_stack = sfr_wr && (sfr_addr == `OFS_STACK_TOP);
wire wr_dp_lo = sfr_wr && (sfr_addr == `OFS_DP_LOW);
wire wr_dp_hi = sfr_wr && (sfr_addr == `OFS_DP_HIGH);
wire wr_trigger = sfr_wr && (sfr_addr == `OFS_ERASE_TRIGGER);
wire wr_page = sfr_wr && (sfr_addr == `OFS_ERASE_PAGE);
wire wr_fctrl = sfr_wr && (sfr_addr == `OFS_FLASH_CTRL);
wire wr_rom_byte = sfr_wr && (sfr_addr == `OFS_SERIAL_ROM_BYTE);
wire wr_rom_cmd = sfr_wr && (sfr_addr == `OFS_SERIAL_ROM_CMD);
wire wr_latch_a = sfr_wr && (sfr_addr == `OFS_IO_LATCH_A);
wire wr_latch_b = sfr_wr && (sfr_addr == `OFS_IO_LATCH_B);
wire wr_latch_c = sfr_wr && (sfr_addr == `OFS_IO_LATCH_C);
wire wr_sel_a = sfr_wr && (sfr_addr == `OFS_IO_SEL_A);
wire wr_sel_b = sfr_wr && (sfr_addr == `OFS_IO_SEL_B);
wire wr_sel_c = sfr_wr && (sfr_addr == `OFS_IO_SEL_C);

// ==========================================================
// Flags word, stack top, data pointer, fetch counter
reg [7:0] flags_nxt;

always @* begin
	flags_nxt = processor_flags_word;
	if (wr_flags) begin
		flags_nxt = sfr_wdata;
	end
	if (alu_flags_we) begin
		flags_nxt[`FLAGS_CARRY_BIT] = carry_flag_in;
		flags_nxt[`FLAGS_HALF_BIT] = half_carry_flag_in;
		flags_nxt[`FLAGS_WRAP_BIT] = signed_wrap_flag_in;
	end
	// Parity is never software-writable
	flags_nxt[`FLAGS_PARITY_BIT] = ^accumulator_reg;
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		processor_flags_word <= `RST_FLAGS_WORD;
		register_bank_base <= 8'h00;
	end else begin
		processor_flags_word <= flags_nxt;
		register_bank_base <= {3'b000,
			flags_nxt[`FLAGS_BANK_HI:`FLAGS_BANK_LO], 3'b000};
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		stack_top <= `RST_STACK_TOP;
	end else if (wr_stack) begin
		stack_top <= sfr_wdata;
	end else if (stack_push) begin
		stack_top <= stack_top + 8'h01;
	end else if (stack_pop) begin
		stack_top <= stack_top - 8'h01;
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		data_pointer_full <= {`RST_DP, `RST_DP};
	end else if (data_pointer_load) begin
		data_pointer_full <= data_pointer_load_value;
	end else if (wr_dp_lo || wr_dp_hi) begin
		if (wr_dp_lo) begin
			data_pointer_full[7:0] <= sfr_wdata;
		end
		if (wr_dp_hi) begin
			data_pointer_full[15:8] <= sfr_wdata;
		end
	end else if (data_pointer_inc) begin
		data_pointer_full <= data_pointer_full + 16'h0001;
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		fetch_counter <= `RST_FETCH;
	end else if (fetch_load) begin
		fetch_counter <= fetch_load_value;
	end else if (fetch_advance) begin
		fetch_counter <= fetch_counter + 16'h0001;
	end
end

// ==========================================================
// I/O latches and direction selects
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		io_pin_a_out <= `RST_IO_LATCH_A;
		io_pin_a_oe <= `RST_IO_SEL;
	end else begin
		if (wr_latch_a) begin
			io_pin_a_out <= sfr_wdata;
		end
		if (wr_sel_a) begin
			io_pin_a_oe <= sfr_wdata;
		end
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		io_pin_b_out <= `RST_IO_LATCH_B;
		io_pin_b_oe <= `RST_IO_SEL;
	end else begin
		if (wr_latch_b) begin
			io_pin_b_out <= sfr_wdata;
		end
		if (wr_sel_b) begin
			io_pin_b_oe <= sfr_wdata;
		end
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		io_pin_c_out <= `RST_IO_LATCH_C;
		io_pin_c_oe <= `RST_IO_SEL;
	end else begin
		if (wr_latch_c) begin
			io_pin_c_out <= sfr_wdata;
		end
		if (wr_sel_c) begin
			io_pin_c_oe <= sfr_wdata;
		end
	end
end

// ==========================================================
// Flash erase trigger
reg [7:0] erase_page_index_r;
reg page_armed_r;
reg bulk_erase_allow_r;

// Any other trigger code matches neither launch term
wire page_go = wr_trigger && (sfr_wdata == `CODE_PAGE_ERASE) &&
	page_armed_r;
wire bulk_go = wr_trigger && (sfr_wdata == `CODE_BULK_ERASE) &&
	bulk_erase_allow_r && debug_port_enabled;

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		erase_page_index_r <= `RST_ERASE_PAGE;
		page_armed_r <= 1'b0;
		bulk_erase_allow_r <= 1'b0;
		page_erase_start <= 1'b0;
		bulk_erase_start <= 1'b0;
		erase_page_out <= 7'h00;
	end else begin
		page_erase_start <= page_go;
		bulk_erase_start <= bulk_go;
		if (page_go) begin
			erase_page_out <= erase_page_index_r[6:0];
		end
		// Setup write in the launch cycle re-arms
		if (wr_page) begin
			erase_page_index_r <= sfr_wdata & `PAGE_INDEX_MAX;
			page_armed_r <= 1'b1;
		end else if (page_go || bulk_go) begin
			page_armed_r <= 1'b0;
		end
		if (wr_fctrl) begin
			bulk_erase_allow_r <=
				sfr_wdata[`FLASH_CTRL_ALLOW_BIT];
		end else if (page_go || bulk_go) begin
			bulk_erase_allow_r <= 1'b0;
		end
	end
end

// ==========================================================
// Serial ROM data and command
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		serial_rom_byte <= `RST_SERIAL_ROM;
		serial_rom_command <= `RST_SERIAL_ROM;
		serial_rom_start <= 1'b0;
	end else begin
		serial_rom_start <= wr_rom_cmd;
		if (wr_rom_byte) begin
			serial_rom_byte <= sfr_wdata;
		end
		if (wr_rom_cmd) begin
			serial_rom_command <= sfr_wdata;
		end
	end
end

// ==========================================================
// Read-back
reg [7:0] rdata_nxt;

always @* begin
	case (sfr_addr)
	`OFS_IO_LATCH_A: rdata_nxt = pin_a_r;
	`OFS_IO_LATCH_B: rdata_nxt = pin_b_r;
	`OFS_IO_LATCH_C: rdata_nxt = pin_c_r;
	`OFS_IO_SEL_A: rdata_nxt = io_pin_a_oe;
	`OFS_IO_SEL_B: rdata_nxt = io_pin_b_oe;
	`OFS_IO_SEL_C: rdata_nxt = io_pin_c_oe;
	`OFS_STACK_TOP: rdata_nxt = stack_top;
	`OFS_DP_LOW: rdata_nxt = data_pointer_full[7:0];
	`OFS_DP_HIGH: rdata_nxt = data_pointer_full[15:8];
	`OFS_FLAGS_WORD: rdata_nxt = processor_flags_word;
	`OFS_ACCUMULATOR: rdata_nxt = accumulator_reg;
	`OFS_ERASE_PAGE: rdata_nxt = erase_page_index_r;
	`OFS_SERIAL_ROM_BYTE: rdata_nxt = serial_rom_byte;
	`OFS_SERIAL_ROM_CMD: rdata_nxt = serial_rom_command;
	`OFS_ERASE_TRIGGER: rdata_nxt = `RST_ERASE_TRIGGER;
	// Trigger and allow bit are write-only
	default: rdata_nxt = `READ_UNMAPPED;
	endcase
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		sfr_rdata <= `READ_UNMAPPED;
	end else if (sfr_rd) begin
		sfr_rdata <= rdata_nxt;
	end
end

endmodule

/* File: verification/mpu_core_special_registers_props.sv */
// Assertion checker for the core special-register bank
`timescale 1ns/1ps
module sfr_chk (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire [7:0] accumulator_reg,
	input wire stack_push,
	input wire fetch_advance,
	input wire fetch_load,
	input wire debug_port_enabled,
	input wire [7:0] processor_flags_word,
	input wire [7:0] register_bank_base,
	input wire [7:0] stack_top,
	input wire [15:0] fetch_counter,
	input wire [7:0] io_pin_a_out,
	input wire [7:0] io_pin_a_oe,
	input wire page_erase_start,
	input wire bulk_erase_start,
	input wire [7:0] serial_rom_command,
	input wire serial_rom_start
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire w94 = sfr_wr && sfr_addr == 8'h94;
	a_bank_base_map: assert property (
		$stable(processor_flags_word[4:3]) |->
		register_bank_base == {3'h0, processor_flags_word[4:3], 3'h0})
		else $error("bank base wrong");
	a_parity_track: assert property (
		!$past(rst) |->
		processor_flags_word[0] == ^$past(accumulator_reg))
		else $error("parity flag wrong");
	a_stack_push: assert property (
		stack_push && !(sfr_wr && sfr_addr == 8'h81) |=>
		stack_top == $past(stack_top) + 8'h01)
		else $error("push did not increment");
	a_fetch_step: assert property (
		fetch_advance && !fetch_load |=>
		fetch_counter == $past(fetch_counter) + 16'h0001)
		else $error("fetch did not advance");
	a_latch_drive: assert property (
		sfr_wr && sfr_addr == 8'h80 |=> io_pin_a_out == $past(sfr_wdata))
		else $error("latch not driven");
	a_dir_select: assert property (
		sfr_wr && sfr_addr == 8'ha2 |=> io_pin_a_oe == $past(sfr_wdata))
		else $error("direction not set");
	a_other_ignored: assert property (
		w94 && sfr_wdata != 8'h55 && sfr_wdata != 8'haa |=>
		!page_erase_start && !bulk_erase_start)
		else $error("stray erase launch");
	a_bulk_debug: assert property (
		w94 && !debug_port_enabled |=> !bulk_erase_start)
		else $error("bulk erase without debug");
	a_launch_once: assert property (
		page_erase_start |=> !page_erase_start)
		else $error("page erase relaunched");
	a_serial_start: assert property (
		sfr_wr && sfr_addr == 8'h9f |=>
		serial_rom_start && serial_rom_command == $past(sfr_wdata))
		else $error("serial start missing");
	c_page: cover property (page_erase_start);
	c_bulk: cover property (bulk_erase_start);
	c_serial: cover property (serial_rom_start);
endmodule

bind mpu_core_special_registers sfr_chk u_chk (.clk_sys, .rst, .sfr_addr,
	.sfr_wdata, .sfr_wr, .accumulator_reg, .stack_push, .fetch_advance,
	.fetch_load, .debug_port_enabled, .processor_flags_word,
	.register_bank_base, .stack_top, .fetch_counter, .io_pin_a_out,
	.io_pin_a_oe, .page_erase_start, .bulk_erase_start,
	.serial_rom_command, .serial_rom_start);

/* File: verification/tb_mpu_core_special_registers.sv */
// Self-checking bench for the core special-register bank
`timescale 1ns/1ps
module tb_mpu_core_special_registers;
	reg clk_sys = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
	reg [7:0] sfr_addr = 0, sfr_wdata = 0, accumulator_reg = 0;
	reg stack_push = 0, stack_pop = 0, fetch_advance = 0, fetch_load = 0;
	reg data_pointer_load = 0, data_pointer_inc = 0, debug_port_enabled = 0;
	reg [15:0] fetch_load_value = 0, data_pointer_load_value = 0;
	reg [7:0] io_pin_a_in = 0, io_pin_b_in = 0, io_pin_c_in = 0;
	wire [7:0] sfr_rdata, processor_flags_word, register_bank_base;
	wire [7:0] stack_top, io_pin_a_out, io_pin_a_oe, io_pin_b_out;
	wire [7:0] io_pin_b_oe, io_pin_c_out, io_pin_c_oe;
	wire [15:0] data_pointer_full, fetch_counter;
	wire page_erase_start, bulk_erase_start, serial_rom_start;
	wire [6:0] erase_page_out;
	wire [7:0] serial_rom_byte, serial_rom_command;
	integer failures = 0, n_checks = 0, cyc = 0, i;
	reg [7:0] exp_f;
	mpu_core_special_registers uut (.clk_sys, .rst, .sfr_addr, .sfr_wdata,
		.sfr_wr, .sfr_rd, .sfr_rdata, .accumulator_reg,
		.alu_flags_we(1'b0), .carry_flag_in(1'b0),
		.half_carry_flag_in(1'b0), .signed_wrap_flag_in(1'b0),
		.stack_push, .stack_pop, .fetch_advance, .fetch_load,
		.fetch_load_value, .data_pointer_load, .data_pointer_load_value,
		.data_pointer_inc, .processor_flags_word, .register_bank_base,
		.stack_top, .data_pointer_full, .fetch_counter, .io_pin_a_in,
		.io_pin_a_out, .io_pin_a_oe, .io_pin_b_in, .io_pin_b_out,
		.io_pin_b_oe, .io_pin_c_in, .io_pin_c_out, .io_pin_c_oe,
		.debug_port_enabled, .page_erase_start, .bulk_erase_start,
		.erase_page_out, .serial_rom_byte, .serial_rom_command,
		.serial_rom_start);
	initial forever #10 clk_sys = ~clk_sys;
	// ==========================================================
	// Shared tasks
	task chk(input string nm, input [15:0] e, input [15:0] g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task tick;
		@(posedge clk_sys);
	endtask
	task wr(input [7:0] a, input [7:0] d);
		tick;
		sfr_wr <= 1;
		sfr_addr <= a;
		sfr_wdata <= d;
		tick;
		sfr_wr <= 0;
		#1;
	endtask
	task rd(input [7:0] a);
		tick;
		sfr_rd <= 1;
		sfr_addr <= a;
		tick;
		sfr_rd <= 0;
		#1;
	endtask
	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task t_stack;
		chk("fetch rst", 16'h0000, fetch_counter);
		rd(8'h81);
		chk("stack rst", 8'h07, sfr_rdata);
		tick;
		stack_push <= 1;
		tick;
		stack_push <= 0;
		stack_pop <= 1;
		#1;
		chk("push", 8'h08, stack_top);
		tick;
		stack_pop <= 0;
		#1;
		chk("pop", 8'h07, stack_top);
		$display("stack test done");
	endtask
	task t_flags;
		for (i = 0; i < 4; i = i + 1) begin
			tick;
			accumulator_reg <= {6'h00, i[1:0]};
			wr(8'hd0, {2'b00, i[0], i[1:0], 1'b0, i[1], 1'b1});
			exp_f = {2'b00, i[0], i[1:0], 1'b0, i[1], ^i[1:0]};
			tick;
			#1;
			chk("bank", {3'h0, i[1:0], 3'h0}, register_bank_base);
			rd(8'hd0);
			chk("flags", exp_f, sfr_rdata);
		end
		$display("flags test done");
	endtask
	task t_count;
		tick;
		data_pointer_load <= 1;
		data_pointer_load_value <= 16'h1234;
		fetch_load <= 1;
		fetch_load_value <= 16'hfffe;
		tick;
		data_pointer_load <= 0;
		fetch_load <= 0;
		fetch_advance <= 1;
		#1;
		chk("dp load", 16'h1234, data_pointer_full);
		repeat (2) tick;
		fetch_advance <= 0;
		#1;
		chk("fetch wrap", 16'h0000, fetch_counter);
		wr(8'h82, 8'hab);
		wr(8'h83, 8'hcd);
		tick;
		data_pointer_inc <= 1;
		tick;
		data_pointer_inc <= 0;
		#1;
		chk("dp bytes", 16'hcdac, data_pointer_full);
		$display("counter test done");
	endtask
	task t_ports;
		chk("out b rst", 8'hff, io_pin_b_out);
		chk("out c rst", 8'h00, io_pin_c_out);
		chk("oe c rst", 8'h00, io_pin_c_oe);
		wr(8'ha2, 8'h0f);
		wr(8'h80, 8'ha5);
		chk("oe a", 8'h0f, io_pin_a_oe);
		chk("out a", 8'ha5, io_pin_a_out);
		wr(8'h91, 8'hf0);
		wr(8'h90, 8'h96);
		wr(8'ha1, 8'h3c);
		wr(8'ha0, 8'h69);
		chk("oe b", 8'hf0, io_pin_b_oe);
		chk("out b", 8'h96, io_pin_b_out);
		chk("oe c", 8'h3c, io_pin_c_oe);
		chk("out c", 8'h69, io_pin_c_out);
		rd(8'ha1);
		chk("sel c rd", 8'h3c, sfr_rdata);
		tick;
		io_pin_a_in <= 8'h3c;
		io_pin_b_in <= 8'h5a;
		io_pin_c_in <= 8'hc3;
		repeat (2) tick;
		rd(8'h80);
		chk("pin a", 8'h3c, sfr_rdata);
		rd(8'h90);
		chk("pin b", 8'h5a, sfr_rdata);
		rd(8'ha0);
		chk("pin c", 8'hc3, sfr_rdata);
		$display("port test done");
	endtask
	task t_erase;
		wr(8'h94, 8'h55);
		chk("unarmed", 1'b0, page_erase_start);
		wr(8'hb7, 8'h7f);
		wr(8'h94, 8'h55);
		chk("page go", 1'b1, page_erase_start);
		chk("page idx", 7'h7f, erase_page_out);
		wr(8'h94, 8'h55);
		chk("page again", 1'b0, page_erase_start);
		wr(8'hb7, 8'h01);
		wr(8'h94, 8'h5a);
		chk("other", 1'b0, page_erase_start);
		wr(8'hb2, 8'h02);
		wr(8'h94, 8'haa);
		chk("no debug", 1'b0, bulk_erase_start);
		tick;
		debug_port_enabled <= 1;
		wr(8'hb2, 8'h02);
		wr(8'h94, 8'haa);
		chk("bulk go", 1'b1, bulk_erase_start);
		wr(8'h94, 8'haa);
		chk("bulk again", 1'b0, bulk_erase_start);
		rd(8'h94);
		chk("trig rd", 8'h00, sfr_rdata);
		$display("erase test done");
	endtask
	task t_serial;
		wr(8'h9e, 8'h3c);
		wr(8'h9f, 8'h01);
		chk("start", 1'b1, serial_rom_start);
		chk("byte", 8'h3c, serial_rom_byte);
		chk("cmd", 8'h01, serial_rom_command);
		tick;
		#1;
		chk("start end", 1'b0, serial_rom_start);
		rd(8'h9e);
		chk("byte rd", 8'h3c, sfr_rdata);
		$display("serial test done");
	endtask
	task t_reset;
		tick;
		rst <= 1;
		tick;
		#1;
		chk("rst stack", 8'h07, stack_top);
		chk("rst dp", 16'h0000, data_pointer_full);
		chk("rst out a", 8'hff, io_pin_a_out);
		chk("rst oe a", 8'h00, io_pin_a_oe);
		chk("rst page", 7'h00, erase_page_out);
		chk("rst cmd", 8'h00, serial_rom_command);
		tick;
		rst <= 0;
		rd(8'h81);
		chk("rst stack rd", 8'h07, sfr_rdata);
		$display("reset test done");
	endtask
	// ==========================================================
	// Timeout and main sequence
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			failures = failures + 1;
			test_done;
		end
	end
	initial begin
		repeat (20) tick;
		rst <= 0;
		#1;
		t_stack;
		t_flags;
		t_count;
		t_ports;
		t_erase;
		t_serial;
		t_reset;
		test_done;
	end
endmodule
